// ==== ieg_top.sv ====
// interrupt enable gating: two enable registers gate eleven sources
// assumes a classic wishbone master, 32-bit data, synchronous requests
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module ieg_top
	import ieg_pkg::*;
(
	input  wire logic        clk_i,      // 100 mhz system clock
	input  wire logic        rst_i,      // synchronous reset, high
	input  wire logic        cyc_i,      // wishbone cycle
	input  wire logic        stb_i,      // wishbone strobe
	input  wire logic        we_i,       // wishbone write
	input  wire logic [7:0]  adr_i,      // wishbone byte address
	input  wire logic [3:0]  sel_i,      // wishbone byte selects
	input  wire logic [31:0] dat_i,      // wishbone write data
	output logic [31:0]      dat_o,      // wishbone read data
	output logic             ack_o,      // wishbone acknowledge
	input  wire logic [10:0] src_req_i,  // raw requests, package index order
	output logic [10:0]      core_req_o, // gated requests toward the core
	output logic             irq_o       // event interrupt, level
);
	////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]  en_pri;         // primary enable register
	logic [3:0]  en_sec;         // secondary enable, implemented bits
	logic [1:0]  evt_stat;       // sticky events
	logic [1:0]  evt_mask;       // event mask
	logic [31:0] rd_data;        // registered read data
	logic        ack;            // registered ack
	logic [7:0]  next_en_pri;    // next primary
	logic [3:0]  next_en_sec;    // next secondary
	logic [1:0]  next_evt_stat;  // next status
	logic [1:0]  next_evt_mask;  // next mask
	logic [31:0] next_rd_data;   // next read data
	logic        next_ack;       // next ack
	logic [10:0] local_en;       // per-source enable vector
	logic [10:0] fwd;            // gated requests
	logic        req_take;       // a bus request taken this cycle
	logic        wr_lane0;       // write hitting the low byte lane
	logic [1:0]  evt_now;        // events seen this cycle

	////////////////////////////////////////////////////////////////////////
	// map enable bits onto the source vector
	always_comb begin
		local_en               = '0;
		local_en[IEG_I_EXT0]   = en_pri[IEG_B_EXT0];
		local_en[IEG_I_TMR0]   = en_pri[IEG_B_TMR0];
		local_en[IEG_I_EXT1]   = en_pri[IEG_B_EXT1];
		local_en[IEG_I_TMR1]   = en_pri[IEG_B_TMR1];
		local_en[IEG_I_UART]   = en_pri[IEG_B_UART];
		local_en[IEG_I_TMR2]   = en_pri[IEG_B_TMR2];
		local_en[IEG_I_PCA]    = en_pri[IEG_B_PCA];
		local_en[IEG_I_CAN]    = en_sec[IEG_B_CAN];
		local_en[IEG_I_ADC]    = en_sec[IEG_B_ADC];
		local_en[IEG_I_CANTIM] = en_sec[IEG_B_CANTIM];
		local_en[IEG_I_SPI]    = en_sec[IEG_B_SPI];
	end

	// one gate per source; combinational so enables act in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < IEG_NSRC; gi++) begin : g_gate
			ieg_gate u_gate (
				.req_i    (src_req_i[gi]),
				.local_i  (local_en[gi]),
				.global_i (en_pri[IEG_B_GLOBAL]),
				.fwd_o    (fwd[gi])
			);
		end
	endgenerate
	assign core_req_o = fwd;

	////////////////////////////////////////////////////////////////////////
	// bus decode: ack one cycle after the request, dropped the next cycle
	assign req_take = cyc_i & stb_i & ~ack;
	assign wr_lane0 = req_take & we_i & sel_i[0];
	assign evt_now[IEG_E_BLOCKED] = |src_req_i & ~en_pri[IEG_B_GLOBAL];
	assign evt_now[IEG_E_PASSED]  = |fwd;

	// register update; a byte write replaces the whole byte, bit access is
	// done by software read-modify-write, each bit stored independently
	always_comb begin
		next_en_pri   = en_pri;
		next_en_sec   = en_sec;
		next_evt_mask = evt_mask;
		next_evt_stat = evt_stat;
		next_rd_data  = rd_data;
		next_ack      = req_take;
		if (wr_lane0) begin
			case (adr_i)
				IEG_OFS_PRIMARY:   next_en_pri   = dat_i[7:0];
				IEG_OFS_SECONDARY: next_en_sec   = dat_i[3:0];
				IEG_OFS_MASK:      next_evt_mask = dat_i[1:0];
				default:           next_en_pri   = en_pri;       // unmapped: ignored
			endcase
		end
		if (req_take && !we_i) begin
			case (adr_i)
				IEG_OFS_PRIMARY:   next_rd_data = {24'h000000, en_pri};
				IEG_OFS_SECONDARY: next_rd_data = {28'h0000000, en_sec};
				IEG_OFS_STATUS: begin
					next_rd_data  = {30'h00000000, evt_stat};
					next_evt_stat = 2'h0; // read clears
				end
				IEG_OFS_MASK:      next_rd_data = {30'h00000000, evt_mask};
				default:           next_rd_data = 32'h00000000; // unmapped reads zero
			endcase
		end
		// new events win over a clearing read
		next_evt_stat = next_evt_stat | evt_now;
	end

	// registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_pri   <= IEG_RST_PRIMARY;
			en_sec   <= IEG_RST_SECONDARY;
			evt_stat <= 2'h0;
			evt_mask <= 2'h0;
			rd_data  <= 32'h00000000;
			ack      <= 1'b0;
		end else begin
			en_pri   <= next_en_pri;
			en_sec   <= next_en_sec;
			evt_stat <= next_evt_stat;
			evt_mask <= next_evt_mask;
			rd_data  <= next_rd_data;
			ack      <= next_ack;
		end
	end

	assign dat_o = rd_data;
	assign ack_o = ack;
	// level interrupt while an unmasked event is pending
	assign irq_o = |(evt_stat & evt_mask);
endmodule

// ==== ieg_pkg.sv ====
// package for the interrupt enable gating block: offsets, fields, resets
// assumes a classic wishbone slave with 32-bit data, one register per word
package ieg_pkg;
	// register byte addresses (printed offsets are multiples of four)
	localparam logic [7:0] IEG_OFS_PRIMARY   = 8'hA8; // primary enable register
	localparam logic [7:0] IEG_OFS_SECONDARY = 8'hE8; // secondary enable register
	localparam logic [7:0] IEG_OFS_STATUS    = 8'hF0; // sticky event status
	localparam logic [7:0] IEG_OFS_MASK      = 8'hF4; // event mask
	// primary enable register fields
	localparam int IEG_B_GLOBAL = 7; // global gate
	localparam int IEG_B_PCA    = 6; // pca gate
	localparam int IEG_B_TMR2   = 5; // timer 2 overflow gate
	localparam int IEG_B_UART   = 4; // serial port gate
	localparam int IEG_B_TMR1   = 3; // timer 1 overflow gate
	localparam int IEG_B_EXT1   = 2; // external interrupt 1 gate
	localparam int IEG_B_TMR0   = 1; // timer 0 overflow gate
	localparam int IEG_B_EXT0   = 0; // external interrupt 0 gate
	// secondary enable register fields
	localparam int IEG_B_SPI    = 3; // spi gate
	localparam int IEG_B_CANTIM = 2; // can timer overrun gate
	localparam int IEG_B_ADC    = 1; // converter gate
	localparam int IEG_B_CAN    = 0; // can controller gate
	// reset values and implemented bits
	localparam logic [7:0] IEG_RST_PRIMARY   = 8'h00; // all disabled
	localparam logic [3:0] IEG_RST_SECONDARY = 4'h0;  // low nibble cleared
	localparam logic [7:0] IEG_SEC_IMPL      = 8'h0F; // implemented secondary bits
	// number of request sources, order of the request vector
	localparam int IEG_NSRC = 11; // sources handled
	localparam int IEG_I_EXT0   = 0;  // req vector index: ext 0
	localparam int IEG_I_TMR0   = 1;  // timer 0
	localparam int IEG_I_EXT1   = 2;  // ext 1
	localparam int IEG_I_TMR1   = 3;  // timer 1
	localparam int IEG_I_UART   = 4;  // serial port
	localparam int IEG_I_TMR2   = 5;  // timer 2
	localparam int IEG_I_PCA    = 6;  // pca
	localparam int IEG_I_CAN    = 7;  // can controller
	localparam int IEG_I_ADC    = 8;  // converter
	localparam int IEG_I_CANTIM = 9;  // can timer overrun
	localparam int IEG_I_SPI    = 10; // spi
	// event status bit positions
	localparam int IEG_E_BLOCKED = 0; // a request arrived while globally gated off
	localparam int IEG_E_PASSED  = 1; // a gated request reached the core
endpackage

// ==== ieg_gate.sv ====
// one source gate: request passes only with global and local enable
// assumes synchronous request levels from the peripheral
`timescale 1ns/1ns
module ieg_gate (
	input  wire logic req_i,    // raw request
	input  wire logic local_i,  // source enable
	input  wire logic global_i, // global enable
	output logic      fwd_o     // request toward the core
);
	// global gate dominates; local gate selects per source
	assign fwd_o = req_i & local_i & global_i;
endmodule

// ==== ieg_top_properties.sv ====
// checker for the interrupt enable gating block, bound to ieg_top
// assumes one clock and a synchronous high reset; shadows the enables
`timescale 1ns/1ns
module ieg_chk
	import ieg_pkg::*;
(
	input wire logic        clk_i,      // system clock
	input wire logic        rst_i,      // synchronous reset, high
	input wire logic        cyc_i,      // bus cycle
	input wire logic        stb_i,      // bus strobe
	input wire logic        we_i,       // bus write
	input wire logic        ack_o,      // bus acknowledge
	input wire logic        irq_o,      // event interrupt
	input wire logic [7:0]  adr_i,      // byte address
	input wire logic [3:0]  sel_i,      // byte selects
	input wire logic [31:0] dat_i,      // write data
	input wire logic [31:0] dat_o,      // read data
	input wire logic [10:0] src_req_i,  // raw requests
	input wire logic [10:0] core_req_o  // gated requests
);
	logic [7:0]  pri, sec; // shadow enables
	logic [1:0]  msk;      // shadow event mask
	logic        tk;       // request taken at this edge
	logic [10:0] en;       // expected open gates
	assign tk = cyc_i & stb_i & ~ack_o;
	assign en = {sec[3:0], pri[6:0]} & {11{pri[7]}};
	// writes land at the taking edge, so the shadow moves with the design
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pri <= 8'h00;
			sec <= 8'h00;
			msk <= 2'h0;
		end else if (tk & we_i & sel_i[0]) begin
			if (adr_i == IEG_OFS_PRIMARY) pri <= dat_i[7:0];
			if (adr_i == IEG_OFS_SECONDARY) sec <= dat_i[7:0] & IEG_SEC_IMPL;
			if (adr_i == IEG_OFS_MASK) msk <= dat_i[1:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_global_off: assert property (!pri[7] |-> core_req_o == 11'h000)
		else $error("request passed with the global gate off");
	chk_primary_gates: assert property (core_req_o[6:0] == (src_req_i[6:0] & en[6:0]))
		else $error("primary gated request wrong");
	chk_secondary_gates: assert property (core_req_o[10:7] == (src_req_i[10:7] & en[10:7]))
		else $error("secondary gated request wrong");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0)
		else $error("outputs not quiet after reset");
	chk_primary_read: assert property (tk && !we_i && adr_i == IEG_OFS_PRIMARY |=> dat_o == {24'h0, pri})
		else $error("primary readback wrong");
	chk_secondary_read: assert property (tk && !we_i && adr_i == IEG_OFS_SECONDARY |=> dat_o == {24'h0, sec})
		else $error("secondary readback wrong");
	chk_ack_pulse: assert property (tk |=> ack_o ##1 !ack_o)
		else $error("acknowledge not a single pulse");
	chk_blocked_irq: assert property (src_req_i != 11'h0 && !pri[7] && msk[0] |-> ##[1:2] irq_o)
		else $error("blocked request raised no interrupt");
endmodule
bind ieg_top ieg_chk u_ieg_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .ack_o(ack_o), .irq_o(irq_o), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .src_req_i(src_req_i), .core_req_o(core_req_o));

// ==== ieg_core_model.sv ====
// core side model: latches the gated requests it would act on
// assumes requests are levels sampled on the system clock
`timescale 1ns/1ns
module ieg_core_model (
	input  wire logic        clk_i,  // system clock
	input  wire logic        rst_i,  // synchronous reset
	input  wire logic [10:0] req_i,  // gated requests
	output logic [10:0]      seen_o  // requests seen at the last edge
);
	// no vectoring or priority here: those sit outside this block
	always_ff @(posedge clk_i) seen_o <= rst_i ? 11'h000 : req_i;
endmodule

// ==== testbench.sv ====
// testbench for the interrupt enable gating block
// assumes classic wishbone access and the core model on the request side
`timescale 1ns/1ns
module testbench
	import ieg_pkg::*;
;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o; // bus
	logic [7:0]  adr_i = 8'h00;                                                   // address
	logic [3:0]  sel_i = 4'h1;                                                    // selects
	logic [31:0] dat_i = 32'h0, dat_o, q, e;                                      // data
	logic [10:0] src_req_i = 11'h000, core_req_o, seen;                           // requests
	int          fails = 0, total_checks = 0;                                     // tallies
	initial forever #5 clk_i = ~clk_i;
	ieg_top u_ieg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.src_req_i(src_req_i), .core_req_o(core_req_o), .irq_o(irq_o));
	ieg_core_model u_ieg_core_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(core_req_o), .seen_o(seen));
	task automatic final_report;
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, g, x);
		end
	endtask
	// one classic cycle; the request is held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			final_report();
		end else begin
			q = dat_o;
			{cyc_i, stb_i} <= 2'b00;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, IEG_OFS_PRIMARY, 0); chk(q, 0);
		wb(0, IEG_OFS_SECONDARY, 0); chk(q, 0);
		src_req_i <= 11'h7FF;
		wb(1, IEG_OFS_PRIMARY, 32'h7F); wb(1, IEG_OFS_SECONDARY, 32'h0F);
		chk(core_req_o, 0);
		// each source alone open, then each source alone closed
		for (int i = 0; i < 11; i++) begin
			e = 32'h1 << i;
			wb(1, IEG_OFS_PRIMARY, 32'h80 | (e & 32'h7F)); wb(1, IEG_OFS_SECONDARY, (e >> 7) & 32'h0F);
			chk(core_req_o, e);
			wb(1, IEG_OFS_PRIMARY, 32'hFF & ~(e & 32'h7F)); wb(1, IEG_OFS_SECONDARY, 32'h0F & ~(e >> 7));
			@(posedge clk_i);
			chk(seen, 32'h7FF & ~e);
		end
		// single bit set by read-modify-write; a write without sel 0 is dropped
		wb(1, IEG_OFS_PRIMARY, 32'h81); wb(0, IEG_OFS_PRIMARY, 0); wb(1, IEG_OFS_PRIMARY, q | 32'h20);
		@(posedge clk_i) sel_i <= 4'hE;
		wb(1, IEG_OFS_PRIMARY, 0);
		sel_i <= 4'h1;
		wb(0, IEG_OFS_PRIMARY, 0); chk(q, 32'hA1);
		wb(1, IEG_OFS_SECONDARY, 32'h05); wb(0, IEG_OFS_SECONDARY, 0); chk(q, 32'h05);
		wb(1, 8'h10, 32'hFF); wb(0, 8'h10, 0); chk(q, 0);
		// blocked request raises the interrupt, masked it stays low
		src_req_i <= 11'h000;
		wb(0, IEG_OFS_STATUS, 0); chk(q, 32'h3);
		wb(1, IEG_OFS_MASK, 32'h3); wb(1, IEG_OFS_PRIMARY, 0);
		for (int m = 3; m >= 2; m--) begin
			wb(1, IEG_OFS_MASK, m);
			@(posedge clk_i) src_req_i <= 11'h001;
			@(posedge clk_i) src_req_i <= 11'h000;
			repeat (3) @(posedge clk_i);
			chk(irq_o, m == 3);
			wb(0, IEG_OFS_STATUS, 0); chk(q, 32'h1);
			repeat (2) @(posedge clk_i);
			chk(irq_o, 0);
		end
		// a forwarded request sets the passed event, unmasked by mask bit 1
		wb(1, IEG_OFS_PRIMARY, 32'h81);
		@(posedge clk_i) src_req_i <= 11'h001;
		@(posedge clk_i) src_req_i <= 11'h000;
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1);
		wb(0, IEG_OFS_STATUS, 0); chk(q, 32'h2);
		// reset in mid-run clears both enable registers again
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, IEG_OFS_PRIMARY, 0); chk(q, 0);
		wb(0, IEG_OFS_SECONDARY, 0); chk(q, 0);
		chk(irq_o, 0);
		final_report();
	end
endmodule
